// ### ssp_pkg.sv
// Shared constants and types for the synchronous serial port
package ssp_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_BUF = 8'h13;
  localparam logic [7:0] ADDR_CON = 8'h14;
  localparam logic [7:0] ADDR_CON2 = 8'h91;
  localparam logic [7:0] ADDR_STAT = 8'h94;
  // Reset values
  localparam logic [7:0] CON_RST = 8'h00;
  localparam logic [7:0] CON2_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  // Status and flags register field positions
  localparam int STAT_SMP_BIT = 7;
  localparam int STAT_CKE_BIT = 6;
  localparam int STAT_BF_BIT = 0;
  localparam int FLAGS_IRQ_BIT = 0;
  // Mode field encodings
  localparam logic [3:0] MODE_SPI_M_LAST = 4'h3;
  localparam logic [3:0] MODE_SPI_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SPI_SLV = 4'h5;
  localparam logic [3:0] MODE_I2C_S7 = 4'h6;
  localparam logic [3:0] MODE_I2C_S10 = 4'h7;
  localparam logic [3:0] MODE_I2C_MST = 4'h8;
  // Master SPI half bit times in clock cycles, per rate code
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_TMR = 7'h40;
  // I2C quarter bit time
  localparam int CLK_PERIOD_NS = 8;
  localparam int I2C_QUARTER_NS = 2500;
  localparam int I2C_Q_CYC = I2C_QUARTER_NS / CLK_PERIOD_NS;
  localparam logic [8:0] I2C_Q_LAST = 9'(I2C_Q_CYC - 1);
  // Byte framing
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] SPI_EDGES = 5'h10;

  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic ckp;
    logic [3:0] mode;
  } ssp_ctrl_t;

  typedef struct packed {
    logic general_call_enable;
    logic ack_status;
    logic ack_data_value;
    logic ack_sequence_enable;
    logic i2c_receive_enable;
    logic stop_request;
    logic repeated_start_request;
    logic start_request;
  } ssp_ctrl2_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_RSTART = 3'b010,
    ST_STOP = 3'b011,
    ST_ACK = 3'b100,
    ST_RX = 3'b101,
    ST_TX = 3'b110
  } ssp_state_t;
endpackage

// ### ssp_port.sv
// Synchronous serial port: SPI master/slave, I2C master sequencer, general call
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module ssp_port import ssp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // SPI pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe_n,
  input wire logic ss_n,
  // I2C pins, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Status levels
  output logic port_interrupt_flag,
  output logic buffer_full
);

  function automatic logic is_spi_master(input logic [3:0] m);
    return m <= MODE_SPI_M_LAST;
  endfunction

  function automatic logic is_spi_slave(input logic [3:0] m);
    return m == MODE_SPI_SLV_SS || m == MODE_SPI_SLV;
  endfunction

  function automatic logic is_i2c_slave(input logic [3:0] m);
    return m == MODE_I2C_S7 || m == MODE_I2C_S10;
  endfunction

  ssp_ctrl_t con_q;
  ssp_ctrl2_t con2_q;
  ssp_state_t st_q, st_d;
  logic smp_q, cke_q, bf_q, irq_q;
  logic [7:0] buf_q, sr_q, sr_d, rdata_q;
  logic busy_q, pend_q, sck_q, sck_prev_q, sdo_q;
  logic [3:0] bits_q, bitn_q, gc_cnt_q;
  logic [4:0] e_q;
  logic [6:0] div_q;
  logic [8:0] qc_q;
  logic [1:0] ph_q;
  logic sda_q, scl_q, sda_n, scl_n, sda_prev_q, scl_prev_q;
  logic [4:0] raw, sync;

  // Every pin input passes two flops; only the second stage is read
  assign raw = {sck_i, sdi, ss_n, sda_i, scl_i};
  generate
    for (genvar i = 0; i < 5; i++) begin : g_sync
      logic a_q, b_q;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          a_q <= 1'b1;
          b_q <= 1'b1;
        end else begin
          a_q <= raw[i];
          b_q <= a_q;
        end
      end
      assign sync[i] = b_q;
    end
  endgenerate

  wire sck_s = sync[4];
  wire sdi_s = sync[3];
  wire ss_s = sync[2];
  wire sda_s = sync[1];
  wire scl_s = sync[0];

  // Mode decode
  wire spi_m = con_q.en && is_spi_master(con_q.mode);
  wire spi_s = con_q.en && is_spi_slave(con_q.mode);
  wire ss_off = spi_s && con_q.mode == MODE_SPI_SLV_SS && ss_s;
  wire i2c_m = con_q.en && con_q.mode == MODE_I2C_MST;
  wire i2c_s = con_q.en && is_i2c_slave(con_q.mode);

  // Register decode
  wire wr_buf = wr && addr == ADDR_BUF;
  wire wr_con = wr && addr == ADDR_CON;
  wire wr_con2 = wr && addr == ADDR_CON2;
  wire wr_stat = wr && addr == ADDR_STAT;
  wire wr_flags = wr && addr == ADDR_FLAGS;
  wire rd_buf = rd && addr == ADDR_BUF;
  wire xfer = busy_q || bits_q != 4'h0;
  wire buf_wr_ok = wr_buf && !xfer && st_q == ST_IDLE;
  wire collision = wr_buf && !buf_wr_ok;

  // SPI edge generation; the rate code is read only in master modes
  wire [6:0] half = con_q.mode[1:0] == 2'b00 ? HALF_DIV4 :
                    con_q.mode[1:0] == 2'b01 ? HALF_DIV16 :
                    con_q.mode[1:0] == 2'b10 ? HALF_DIV64 : HALF_TMR;
  wire tick = spi_m && busy_q && div_q == half - 7'h01;
  wire tog = tick && e_q != SPI_EDGES;
  wire s_rise = spi_s && !ss_off && sck_s && !sck_prev_q;
  wire s_fall = spi_s && !ss_off && !sck_s && sck_prev_q;
  wire rise = spi_m ? tog && !sck_q : s_rise;
  wire fall = spi_m ? tog && sck_q : s_fall;
  wire out_rise = cke_q ~^ con_q.ckp;
  wire out_ev = out_rise ? rise : fall;
  wire samp_edge = out_rise ? fall : rise;
  // End-of-bit sampling only makes sense where we own the clock
  wire smp_eff = spi_m && smp_q;
  wire pend_set = samp_edge && smp_eff;
  wire samp_now = (samp_edge && !smp_eff) || (pend_q && tick);
  wire spi_done = samp_now && bits_q == LAST_BIT;

  // I2C master sequencing
  wire q_tick = st_q != ST_IDLE && qc_q == I2C_Q_LAST;
  wire bit_st = st_q == ST_TX || st_q == ST_RX;
  wire i2c_samp = q_tick && ph_q == 2'd2 && st_q == ST_RX;
  wire i2c_shift = q_tick && ph_q == 2'd3 && st_q == ST_TX && bitn_q != BYTE_BITS;
  wire ack_smp = q_tick && ph_q == 2'd2 && st_q == ST_TX && bitn_q == BYTE_BITS;
  wire rx_done = q_tick && ph_q == 2'd3 && st_q == ST_RX && bitn_q == LAST_BIT;
  wire seq_done = q_tick && ph_q == 2'd3 &&
                  (!bit_st || rx_done || bitn_q == BYTE_BITS);

  // I2C slave general call watch
  wire gc_bit = i2c_s && scl_s && !scl_prev_q && gc_cnt_q != BYTE_BITS;
  wire gc_start = i2c_s && scl_s && scl_prev_q && !sda_s && sda_prev_q;
  wire gc_hit = gc_bit && gc_cnt_q == LAST_BIT && con2_q.general_call_enable &&
                {sr_q[6:0], sda_s} == GC_ADDR;

  always_comb begin
    sr_d = sr_q;
    if (buf_wr_ok)
      sr_d = wdata;
    else if (samp_now)
      sr_d = {sr_q[6:0], sdi_s};
    else if (i2c_samp || gc_bit)
      sr_d = {sr_q[6:0], sda_s};
    else if (i2c_shift)
      sr_d = {sr_q[6:0], 1'b0};
  end

  always_comb begin
    st_d = ST_IDLE;
    if (buf_wr_ok && i2c_m)
      st_d = ST_TX;
    else if (con2_q.start_request)
      st_d = ST_START;
    else if (con2_q.repeated_start_request)
      st_d = ST_RSTART;
    else if (con2_q.stop_request)
      st_d = ST_STOP;
    else if (con2_q.i2c_receive_enable)
      st_d = ST_RX;
    else if (con2_q.ack_sequence_enable)
      st_d = ST_ACK;
  end

  // Line levels for the phase that the next quarter tick enters
  always_comb begin
    scl_n = ph_q == 2'd1 || ph_q == 2'd2;
    case (st_q)
      ST_START: begin
        sda_n = ph_q == 2'd0;
        scl_n = ph_q < 2'd2;
      end
      ST_RSTART: sda_n = ph_q < 2'd2;
      ST_STOP: begin
        sda_n = ph_q >= 2'd2;
        scl_n = ph_q != 2'd0;
      end
      ST_ACK: sda_n = con2_q.ack_data_value;
      ST_TX: sda_n = bitn_q == BYTE_BITS ? 1'b1 : sr_q[7];
      default: sda_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !i2c_m) begin
      st_q <= ST_IDLE;
      ph_q <= 2'd0;
      qc_q <= 9'h000;
      bitn_q <= 4'h0;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
    end else if (st_q == ST_IDLE) begin
      st_q <= st_d;
    end else begin
      qc_q <= q_tick ? 9'h000 : qc_q + 9'h001;
      if (q_tick) begin
        ph_q <= ph_q + 2'd1;
        sda_q <= sda_n;
        scl_q <= scl_n;
        if (bit_st && ph_q == 2'd3)
          bitn_q <= bitn_q + 4'h1;
        if (seq_done) begin
          st_q <= ST_IDLE;
          bitn_q <= 4'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      con2_q <= ssp_ctrl2_t'(CON2_RST);
    end else begin
      // Request bits stay frozen while a sequence runs
      if (wr_con2)
        con2_q <= st_q == ST_IDLE ? wdata : {wdata[7:5], con2_q[4:0]};
      if (ack_smp)
        con2_q.ack_status <= sda_s;
      if (seq_done && st_q == ST_START)
        con2_q.start_request <= 1'b0;
      if (seq_done && st_q == ST_RSTART)
        con2_q.repeated_start_request <= 1'b0;
      if (seq_done && st_q == ST_STOP)
        con2_q.stop_request <= 1'b0;
      if (rx_done)
        con2_q.i2c_receive_enable <= 1'b0;
      if (seq_done && st_q == ST_ACK)
        con2_q.ack_sequence_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !(spi_m || spi_s) || ss_off) begin
      busy_q <= 1'b0;
      bits_q <= 4'h0;
      e_q <= 5'h00;
      pend_q <= 1'b0;
      div_q <= 7'h00;
    end else begin
      if (buf_wr_ok && spi_m)
        busy_q <= 1'b1;
      else if (spi_done)
        busy_q <= 1'b0;
      div_q <= (!busy_q || tick) ? 7'h00 : div_q + 7'h01;
      if (spi_done)
        e_q <= 5'h00;
      else if (tog)
        e_q <= e_q + 5'h01;
      if (samp_now)
        bits_q <= spi_done ? 4'h0 : bits_q + 4'h1;
      pend_q <= pend_set || (pend_q && !tick);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      sck_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
      gc_cnt_q <= BYTE_BITS;
      sr_q <= BUF_RST;
    end else begin
      sck_prev_q <= sck_s;
      sda_prev_q <= sda_s;
      scl_prev_q <= scl_s;
      sr_q <= sr_d;
      if (!busy_q)
        sck_q <= con_q.ckp;
      else if (tog)
        sck_q <= !sck_q;
      if (buf_wr_ok)
        sdo_q <= wdata[7];
      else if (out_ev)
        sdo_q <= samp_now ? sr_q[6] : sr_q[7];
      if (gc_start)
        gc_cnt_q <= 4'h0;
      else if (gc_bit)
        gc_cnt_q <= gc_cnt_q + 4'h1;
    end
  end

  // Register file; hardware sets beat a clearing write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      con_q <= ssp_ctrl_t'(CON_RST);
      smp_q <= 1'b0;
      cke_q <= 1'b0;
      buf_q <= BUF_RST;
      bf_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (wr_con)
        con_q <= wdata;
      if (collision)
        con_q.write_collision_flag <= 1'b1;
      if (wr_stat) begin
        smp_q <= wdata[STAT_SMP_BIT];
        cke_q <= wdata[STAT_CKE_BIT];
      end
      if (rd_buf)
        bf_q <= 1'b0;
      if (spi_done || rx_done)
        bf_q <= 1'b1;
      if (spi_done)
        buf_q <= sr_d;
      else if (rx_done)
        buf_q <= sr_q;
      if (wr_flags && !wdata[FLAGS_IRQ_BIT])
        irq_q <= 1'b0;
      if (spi_done || seq_done || gc_hit)
        irq_q <= 1'b1;
      rdata_q <= 8'h00;
      if (rd) begin
        case (addr)
          ADDR_BUF: rdata_q <= buf_q;
          ADDR_CON: rdata_q <= con_q;
          ADDR_CON2: rdata_q <= con2_q;
          ADDR_STAT: rdata_q <= {smp_q, cke_q, 5'h00, bf_q};
          ADDR_FLAGS: rdata_q <= {7'h00, irq_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign rdata = rdata_q;
  assign sck_o = sck_q;
  assign sck_oe_n = !spi_m;
  assign sdo_o = sdo_q;
  assign sdo_oe_n = !(spi_m || (spi_s && !ss_off));
  assign sda_o = 1'b0;
  assign sda_oe_n = !(i2c_m && !sda_q);
  assign scl_o = 1'b0;
  assign scl_oe_n = !(i2c_m && !scl_q);
  assign port_interrupt_flag = irq_q;
  assign buffer_full = bf_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_gc_irq;
    gc_hit |=> irq_q;
  endproperty
  a_gc_irq: assert property (p_gc_irq) else $error("general call missed");

  property p_ack_stat;
    ack_smp |=> con2_q.ack_status == $past(sda_s);
  endproperty
  a_ack_stat: assert property (p_ack_stat) else $error("ack status wrong");

  property p_ack_data;
    (st_q == ST_ACK && ph_q == 2'd2) |-> sda_q == con2_q.ack_data_value;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("ack data wrong");

  property p_ack_clr;
    (seq_done && st_q == ST_ACK) |=> !con2_q.ack_sequence_enable && st_q == ST_IDLE;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack enable kept");

  property p_start;
    (st_q == ST_START && ph_q == 2'd2) |-> !sda_q && scl_q;
  endproperty
  a_start: assert property (p_start) else $error("start shape wrong");

  property p_no_queue;
    (wr_con2 && st_q != ST_IDLE && !con2_q.stop_request) |=> !con2_q.stop_request;
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("request queued");

  property p_byte;
    spi_done |=> bf_q && irq_q && buf_q == $past(sr_d);
  endproperty
  a_byte: assert property (p_byte) else $error("byte not buffered");

  property p_idle_clk;
    (spi_m && !busy_q)[*2] |-> sck_o == $past(con_q.ckp);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");

  property p_write_collision_flag;
    (wr_buf && xfer) |=> con_q.write_collision_flag &&
      (sr_q == $past(sr_q) || sr_q == {$past(sr_q[6:0]), $past(sdi_s)});
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");

  property p_mclk;
    spi_m |-> !sck_oe_n && sdo_oe_n == 1'b0;
  endproperty
  a_mclk: assert property (p_mclk) else $error("master not driving");

endmodule // ssp_port

// ### ssp_peer.sv
// SPI slave peer that trades one byte with the port acting as master
`timescale 1ns/1ps
module ssp_peer (
  // Bus pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Set-up from the bench
  input wire logic ckp,
  input wire logic cke,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  int n;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    n = 8;
  end
  // Outside a frame the line shows the inverse of its last level
  always @(posedge load) begin
    sh = tx_byte;
    n = 0;
    miso = cke ? tx_byte[7] : ~miso;
  end
  // Sample on the leading edge when cke is set, else on the trailing one
  always @(sck) begin
    if ((sck !== ckp) == cke) begin
      rx_byte = {rx_byte[6:0], mosi};
      n = n + 1;
    end else if (n >= 8) begin
      miso = ~miso;
    end else if (cke) begin
      sh = sh << 1;
      miso = sh[7];
    end else begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule // ssp_peer

// ### tb.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module tb import ssp_pkg::*;;
  logic clk, rst_n, wr, rd, ckp, cke, load, sdi, ss_n;
  logic s, sda_drv, scl_drv;
  logic [7:0] addr, wdata, rdata, tx, prx, v, m;
  logic sck_o, sck_oe_n, sdo_o, sdo_oe_n, sda_oe_n, scl_oe_n, flag, bf;
  int err_total, num_checks, cyc;

  ssp_port i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_i(sck_o), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .ss_n(ss_n), .sda_i(sda_oe_n & sda_drv), .sda_o(),
    .sda_oe_n(sda_oe_n), .scl_i(scl_oe_n & scl_drv), .scl_o(), .scl_oe_n(scl_oe_n),
    .port_interrupt_flag(flag), .buffer_full(bf));
  ssp_peer i_peer (.sck(sck_o), .mosi(sdo_o), .miso(sdi), .ckp(ckp), .cke(cke),
    .load(load), .tx_byte(tx), .rx_byte(prx));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] spi_con(logic c, logic [1:0] r);
    return {2'b00, 1'b1, c, 2'b00, r};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask

  task automatic wait_flag();
    for (int i = 0; i < 20000 && flag !== 1'b1; i++) @(posedge clk);
    #1 chk("interrupt flag", 8'h01, {7'h00, flag});
  endtask

  // Polls the request bits until hardware drops them
  task automatic wait_clr(input logic [7:0] mask);
    logic [7:0] d;
    d = mask;
    for (int i = 0; i < 1000 && (d & mask) != 8'h00; i++) rd_reg(ADDR_CON2, d);
    chk("request bits", 8'h00, d & mask);
  endtask

  // Plays an I2C master toward the slave port: start, then one address byte
  task automatic gc_frame(input logic g, input logic [7:0] a);
    wr_reg(ADDR_CON2, {g, 7'h00});
    wr_reg(ADDR_FLAGS, 8'h00);
    sda_drv <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      scl_drv <= 1'b0;
      repeat (4) @(posedge clk);
      sda_drv <= a[i];
      repeat (4) @(posedge clk);
      scl_drv <= 1'b1;
      repeat (8) @(posedge clk);
    end
    chk("general call", {7'h00, g && a == 8'h00}, {7'h00, flag});
    scl_drv <= 1'b0;
    repeat (4) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (4) @(posedge clk);
    scl_drv <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Slave side of a master receive: data changes only while SCL is low
  task automatic i2c_feed(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      while (!scl_oe_n) @(posedge clk);
      while (scl_oe_n) @(posedge clk);
    end
    sda_drv <= 1'b1;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, wr, rd, ckp, cke, load} = 6'b0;
    addr = 8'h00;
    wdata = 8'h00;
    tx = 8'h00;
    ss_n = 1'b1;
    {sda_drv, scl_drv} = 2'b11;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(98420));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk_reg("control two", ADDR_CON2, CON2_RST);
    chk_reg("control", ADDR_CON, CON_RST);
    chk_reg("unmapped", 8'h55, 8'h00);
    v = 8'($urandom());
    wr_reg(ADDR_CON2, v);
    chk_reg("control two", ADDR_CON2, v);
    wr_reg(ADDR_CON2, 8'h00);
    $display("test registers done");
    // All four polarity and edge pairs, random data both ways
    for (int k = 0; k < 4; k++) begin
      ckp = k[1];
      cke = k[0];
      s = k[0] ^ k[1];
      tx = 8'($urandom());
      m = 8'($urandom());
      wr_reg(ADDR_CON, 8'h00);
      wr_reg(ADDR_STAT, {s, cke, 6'h00});
      wr_reg(ADDR_CON, spi_con(ckp, 2'h1));
      wr_reg(ADDR_FLAGS, 8'h00);
      load <= 1'b1;
      wr_reg(ADDR_BUF, m);
      load <= 1'b0;
      wr_reg(ADDR_BUF, ~m);
      chk_reg("collision", ADDR_CON, spi_con(ckp, 2'h1) | 8'h80);
      wait_flag();
      chk("full", 8'h01, {7'h00, bf});
      chk_reg("received", ADDR_BUF, tx);
      chk("peer received", m, prx);
      chk("idle clock", {7'h00, ckp}, {7'h00, sck_o});
      chk("clock drive", 8'h00, {7'h00, sck_oe_n});
      chk_reg("status", ADDR_STAT, {s, cke, 6'h00});
    end
    wr_reg(ADDR_CON, 8'h25);
    #1 chk("slave clock", 8'h01, {7'h00, sck_oe_n});
    wr_reg(ADDR_CON, 8'h24);
    repeat (4) @(posedge clk);
    chk("deselected out", 8'h01, {7'h00, sdo_oe_n});
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("selected out", 8'h00, {7'h00, sdo_oe_n});
    ss_n <= 1'b1;
    $display("test spi done");
    wr_reg(ADDR_CON, 8'h26);
    gc_frame(1'b1, 8'h00);
    gc_frame(1'b0, 8'h00);
    gc_frame(1'b1, 8'($urandom()));
    $display("test general call done");
    wr_reg(ADDR_CON, 8'h00);
    wr_reg(ADDR_CON, 8'h28);
    wr_reg(ADDR_FLAGS, 8'h00);
    wr_reg(ADDR_CON2, 8'h01);
    wait_clr(8'h01);
    chk("start wire", 8'h00, {6'h00, sda_oe_n, scl_oe_n});
    wr_reg(ADDR_FLAGS, 8'h00);
    wr_reg(ADDR_BUF, 8'($urandom()));
    wr_reg(ADDR_CON2, 8'h04);
    chk_reg("busy request", ADDR_CON2, 8'h00);
    wait_flag();
    // Nobody acknowledges, so the pulled-up line reads as a refusal
    chk_reg("ack status", ADDR_CON2, 8'h40);
    v = 8'($urandom());
    wr_reg(ADDR_CON2, 8'h08);
    i2c_feed(v);
    wait_clr(8'h08);
    chk("full", 8'h01, {7'h00, bf});
    chk_reg("i2c received", ADDR_BUF, v);
    m = {7'h00, 1'($urandom())};
    wr_reg(ADDR_CON2, {2'b00, m[0], 5'h10});
    wait_clr(8'h10);
    chk("ack wire", m, {7'h00, sda_oe_n});
    wr_reg(ADDR_CON2, 8'h04);
    wait_clr(8'h04);
    chk("stop wire", 8'h03, {6'h00, sda_oe_n, scl_oe_n});
    $display("test i2c done");
    tally_and_finish();
  end
endmodule // tb
